// ==== rtl/lsi_pkg.sv ====
// Functional notes
// - Rotate bit shows live condition when disabled.
// - Enabled rotate latches on rise, IRQ low, W1C.
// - Window bit live or latched, W1C, IRQ.
// - Trip bit live or latched, W1C, IRQ.
// - Filter overflow flags in bits 7..4.
// - Mixer, phase, gain overflow in bits 3..0.
// - Offset_trim_ovf bit 0, rest reserved.
// - Check register bits 7..6 read zero.
// - All flags reset to zero.
// - Lock bit 3 behaves like others.
package lsi_pkg;

	// Width of the internal register address carried from the serial port.
	localparam int ADDR_W = 12;
	// Width of one register.
	localparam int DATA_W = 8;
	// Number of alignment event flags handled here.
	localparam int NUM_ALIGN = 4;

	// Register addresses.
	localparam logic [ADDR_W-1:0] ALIGN_STATUS_ADDR = 12'h025;
	localparam logic [ADDR_W-1:0] DP_OVF_ADDR = 12'h026;
	localparam logic [ADDR_W-1:0] DC_OVF_ADDR = 12'h027;
	localparam logic [ADDR_W-1:0] LINK_CHECK_ADDR = 12'h030;

	// Bit positions in the alignment status register.
	localparam int LOCK_BIT = 3;
	localparam int ROTATE_BIT = 2;
	localparam int WINDOW_BIT = 1;
	localparam int TRIP_BIT = 0;

	// Bit positions in the datapath overflow register.
	localparam int PROG_FIR_BIT = 7;
	localparam int INTERP1_BIT = 6;
	localparam int INTERP2_BIT = 5;
	localparam int INTERP3_BIT = 4;
	localparam int EIGHTH_MIX_BIT = 3;
	localparam int NCO_MIX_BIT = 2;
	localparam int PHASE_TRIM_BIT = 1;
	localparam int GAIN_TRIM_BIT = 0;

	// Bit position of the Offset_trim_ovf flag.
	localparam int OFFSET_TRIM_BIT = 0;
	// Number of live link parameter check bits below the reserved pair.
	localparam int CHECK_W = 6;

	// Reset values.
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam logic [NUM_ALIGN-1:0] ALIGN_RESET = 4'h0;
	localparam logic [CHECK_W-1:0] CHECK_RESET = 6'h00;
	// Value returned for reserved bits and unmapped addresses.
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

	// Address comparison shared by the read and the write decode.
	function automatic logic lsi_hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] target);
		lsi_hit = (addr == target);
	endfunction

endpackage

// ==== rtl/lsi_core_if.sv ====
`timescale 1ns/10ps
// Carries the two status groups between the top and its worker modules.
interface lsi_core_if;
	// Alignment group: raw conditions, enables and write-one clear mask.
	logic [lsi_pkg::NUM_ALIGN-1:0] align_cond;
	logic [lsi_pkg::NUM_ALIGN-1:0] align_en;
	logic [lsi_pkg::NUM_ALIGN-1:0] align_clear;
	// Alignment group: sampled live status and latched event flags.
	logic [lsi_pkg::NUM_ALIGN-1:0] align_live;
	logic [lsi_pkg::NUM_ALIGN-1:0] align_latch;
	// Overflow group: raw inputs and their registered copies.
	logic [lsi_pkg::DATA_W-1:0] dp_ovf_in;
	logic [lsi_pkg::DATA_W-1:0] dp_ovf;
	logic dc_ovf_in;
	logic dc_ovf;
	logic [lsi_pkg::CHECK_W-1:0] chk_in;
	logic [lsi_pkg::CHECK_W-1:0] chk;

	modport evt (input align_cond, align_en, align_clear, output align_live, align_latch);
	modport ovf (input dp_ovf_in, dc_ovf_in, chk_in, output dp_ovf, dc_ovf, chk);
	modport top (output align_cond, align_en, align_clear, dp_ovf_in, dc_ovf_in, chk_in,
		input align_live, align_latch, dp_ovf, dc_ovf, chk);
endinterface

// ==== rtl/lsi_event_flags.sv ====
`timescale 1ns/10ps
// Live-or-latched event flags for the lane alignment conditions.
module lsi_event_flags (
	input wire logic clk,
	input wire logic rst,
	lsi_core_if.evt bus
);

	// All state of the flag logic.
	typedef struct packed {
		logic [lsi_pkg::NUM_ALIGN-1:0] cond_q;
		logic [lsi_pkg::NUM_ALIGN-1:0] latch;
	} lsi_evt_state_t;

	// Present and next state.
	lsi_evt_state_t st;
	lsi_evt_state_t next_st;

	// Each flag samples its condition; enabled flags detect a rising edge and latch it.
	// A set in the same cycle as a clear wins, so no event is lost.
	always_comb begin
		next_st = st;
		next_st.cond_q = bus.align_cond;
		for (int i = 0; i < lsi_pkg::NUM_ALIGN; i++) begin
			if (!bus.align_en[i]) begin
				// Disabled flags hold no latch; the read shows live status.
				next_st.latch[i] = 1'b0;
			end else begin
				if (bus.align_clear[i]) begin
					// Software wrote a one to this bit.
					next_st.latch[i] = 1'b0;
				end
				if (bus.align_cond[i] && !st.cond_q[i]) begin
					// Rising edge of the condition sets the flag.
					next_st.latch[i] = 1'b1;
				end
			end
		end
	end

	// State register with synchronous reset to all zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// The sampled condition doubles as the live view.
	assign bus.align_live = st.cond_q;
	assign bus.align_latch = st.latch;

endmodule

// ==== rtl/lsi_overflow_capture.sv ====
`timescale 1ns/10ps
// Registers the read-only datapath overflow and parameter check status.
module lsi_overflow_capture (
	input wire logic clk,
	input wire logic rst,
	lsi_core_if.ovf bus
);

	// All state of the overflow capture.
	typedef struct packed {
		logic [lsi_pkg::DATA_W-1:0] dp;
		logic dc;
		logic [lsi_pkg::CHECK_W-1:0] chk;
	} lsi_ovf_state_t;

	// Present and next state.
	lsi_ovf_state_t st;
	lsi_ovf_state_t next_st;

	// The flags follow the datapath one cycle late; software cannot write them.
	always_comb begin
		next_st.dp = bus.dp_ovf_in;
		next_st.dc = bus.dc_ovf_in;
		next_st.chk = bus.chk_in;
	end

	// State register with synchronous reset to all zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bus.dp_ovf = st.dp;
	assign bus.dc_ovf = st.dc;
	assign bus.chk = st.chk;

endmodule

// ==== rtl/lsi_top.sv ====
`timescale 1ns/10ps
// Lane alignment event flags and datapath overflow status, reached through
// the internal register port that the serial control port drives.
module lsi_top (
	// Core clock.
	input wire logic CLK,
	// Synchronous active-high reset.
	input wire logic RST,
	// Register address from the serial control port.
	input wire logic [lsi_pkg::ADDR_W-1:0] REG_ADDR,
	// One-cycle write strobe.
	input wire logic REG_WR,
	// Write data.
	input wire logic [lsi_pkg::DATA_W-1:0] REG_WDATA,
	// One-cycle read strobe.
	input wire logic REG_RD,
	// Read data, valid with REG_RVALID.
	output logic [lsi_pkg::DATA_W-1:0] REG_RDATA,
	// Read answer strobe, one cycle after REG_RD.
	output logic REG_RVALID,
	// Alignment lock condition.
	input wire logic ALIGN_LOCKED_COND,
	// Alignment rotate condition.
	input wire logic FRAME_ROTATE_COND,
	// Alignment phase outside the limit window.
	input wire logic PHASE_WINDOW_COND,
	// Alignment trip condition.
	input wire logic ALIGN_TRIP_COND,
	// Interrupt enables for the four alignment flags.
	input wire logic LOCK_IRQ_ENABLE,
	input wire logic ROTATE_IRQ_ENABLE,
	input wire logic WINDOW_IRQ_ENABLE,
	input wire logic TRIP_IRQ_ENABLE,
	// Overflow indications from the datapath stages.
	input wire logic PROG_FIR_OVF,
	input wire logic INTERP_STAGE1_OVF,
	input wire logic INTERP_STAGE2_OVF,
	input wire logic INTERP_STAGE3_OVF,
	input wire logic EIGHTH_RATE_MIX_OVF,
	input wire logic NCO_MIX_OVF,
	input wire logic PHASE_TRIM_OVF,
	input wire logic GAIN_TRIM_OVF,
	input wire logic OFFSET_TRIM_OVF,
	// Link parameter check errors for the low six bits.
	input wire logic [lsi_pkg::CHECK_W-1:0] LINK_CHECK_ERR,
	// Active-low interrupt request.
	output logic IRQ_N
);

	// All state of the top: the read answer and the interrupt line.
	typedef struct packed {
		logic [lsi_pkg::DATA_W-1:0] rdata;
		logic rvalid;
		logic irq_n;
	} lsi_top_state_t;

	// Present and next state.
	lsi_top_state_t st;
	lsi_top_state_t next_st;

	// Link to the worker modules.
	lsi_core_if core ();

	// Combined view of the alignment register, live or latched per bit.
	logic [lsi_pkg::NUM_ALIGN-1:0] align_view;
	// Write decode for the alignment register.
	logic align_wr;

	// Alignment flags and their latches.
	lsi_event_flags u_events (
		.clk(CLK),
		.rst(RST),
		.bus(core.evt)
	);

	// Read-only overflow and check flags.
	lsi_overflow_capture u_overflow (
		.clk(CLK),
		.rst(RST),
		.bus(core.ovf)
	);

	// Route the alignment conditions and their enables into the flag bank.
	always_comb begin
		core.align_cond = '0;
		core.align_cond[lsi_pkg::LOCK_BIT] = ALIGN_LOCKED_COND;
		core.align_cond[lsi_pkg::ROTATE_BIT] = FRAME_ROTATE_COND;
		core.align_cond[lsi_pkg::WINDOW_BIT] = PHASE_WINDOW_COND;
		core.align_cond[lsi_pkg::TRIP_BIT] = ALIGN_TRIP_COND;
		core.align_en = '0;
		core.align_en[lsi_pkg::LOCK_BIT] = LOCK_IRQ_ENABLE;
		core.align_en[lsi_pkg::ROTATE_BIT] = ROTATE_IRQ_ENABLE;
		core.align_en[lsi_pkg::WINDOW_BIT] = WINDOW_IRQ_ENABLE;
		core.align_en[lsi_pkg::TRIP_BIT] = TRIP_IRQ_ENABLE;
	end

	// Route the overflow indications into their register bit positions.
	always_comb begin
		core.dp_ovf_in = lsi_pkg::REG_RESET;
		core.dp_ovf_in[lsi_pkg::PROG_FIR_BIT] = PROG_FIR_OVF;
		core.dp_ovf_in[lsi_pkg::INTERP1_BIT] = INTERP_STAGE1_OVF;
		core.dp_ovf_in[lsi_pkg::INTERP2_BIT] = INTERP_STAGE2_OVF;
		core.dp_ovf_in[lsi_pkg::INTERP3_BIT] = INTERP_STAGE3_OVF;
		core.dp_ovf_in[lsi_pkg::EIGHTH_MIX_BIT] = EIGHTH_RATE_MIX_OVF;
		core.dp_ovf_in[lsi_pkg::NCO_MIX_BIT] = NCO_MIX_OVF;
		core.dp_ovf_in[lsi_pkg::PHASE_TRIM_BIT] = PHASE_TRIM_OVF;
		core.dp_ovf_in[lsi_pkg::GAIN_TRIM_BIT] = GAIN_TRIM_OVF;
		core.dc_ovf_in = OFFSET_TRIM_OVF;
		core.chk_in = LINK_CHECK_ERR;
	end

	// A write of ones to the alignment register clears those latched flags.
	// Writes to the read-only registers are dropped without any answer,
	// since the port has no error signalling to report them with.
	assign align_wr = REG_WR && lsi_pkg::lsi_hit(REG_ADDR, lsi_pkg::ALIGN_STATUS_ADDR);
	assign core.align_clear = align_wr ? REG_WDATA[lsi_pkg::NUM_ALIGN-1:0]
		: lsi_pkg::ALIGN_RESET;

	// Each bit reads its latch when enabled and the live condition otherwise.
	assign align_view = (core.align_en & core.align_latch)
		| (~core.align_en & core.align_live);

	// Read mux, answer register and interrupt line.
	always_comb begin
		next_st = st;
		next_st.rvalid = REG_RD;
		if (REG_RD) begin
			if (lsi_pkg::lsi_hit(REG_ADDR, lsi_pkg::ALIGN_STATUS_ADDR)) begin
				// Upper nibble belongs to flags kept elsewhere and reads zero here.
				next_st.rdata = lsi_pkg::READ_ZERO;
				next_st.rdata[lsi_pkg::NUM_ALIGN-1:0] = align_view;
			end else if (lsi_pkg::lsi_hit(REG_ADDR, lsi_pkg::DP_OVF_ADDR)) begin
				// All eight bits are datapath overflow flags.
				next_st.rdata = core.dp_ovf;
			end else if (lsi_pkg::lsi_hit(REG_ADDR, lsi_pkg::DC_OVF_ADDR)) begin
				// Only bit 0 is defined; the reserved bits read zero.
				next_st.rdata = lsi_pkg::READ_ZERO;
				next_st.rdata[lsi_pkg::OFFSET_TRIM_BIT] = core.dc_ovf;
			end else if (lsi_pkg::lsi_hit(REG_ADDR, lsi_pkg::LINK_CHECK_ADDR)) begin
				// The top two bits are reserved and always zero.
				next_st.rdata = lsi_pkg::READ_ZERO;
				next_st.rdata[lsi_pkg::CHECK_W-1:0] = core.chk;
			end else begin
				// Addresses this block does not own read as zero.
				next_st.rdata = lsi_pkg::READ_ZERO;
			end
		end
		// The line stays low while any enabled flag is latched.
		next_st.irq_n = ~|(core.align_latch & core.align_en);
	end

	// State register; reset leaves the line released and the read data zero.
	always_ff @(posedge CLK) begin
		if (RST) begin
			st.rdata <= lsi_pkg::REG_RESET;
			st.rvalid <= 1'b0;
			st.irq_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register.
	assign REG_RDATA = st.rdata;
	assign REG_RVALID = st.rvalid;
	assign IRQ_N = st.irq_n;

endmodule

// ==== testbench/lsi_monitor.sv ====
`timescale 1ns/10ps
// Watches the register port and the interrupt line of the status block.
module lsi_monitor (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [lsi_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [lsi_pkg::DATA_W-1:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic ALIGN_LOCKED_COND,
	input wire logic FRAME_ROTATE_COND,
	input wire logic PHASE_WINDOW_COND,
	input wire logic ALIGN_TRIP_COND,
	input wire logic LOCK_IRQ_ENABLE,
	input wire logic ROTATE_IRQ_ENABLE,
	input wire logic WINDOW_IRQ_ENABLE,
	input wire logic TRIP_IRQ_ENABLE,
	input wire logic IRQ_N
);
	// Enables gathered so that a change of any one of them can be seen.
	logic [3:0] en;
	assign en = {LOCK_IRQ_ENABLE, ROTATE_IRQ_ENABLE, WINDOW_IRQ_ENABLE, TRIP_IRQ_ENABLE};
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// A read is answered one cycle later, and nothing else is answered.
	property p_rd_ans; REG_RD |=> REG_RVALID; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_no_ans; !REG_RD |=> !REG_RVALID; endproperty
	a_no_ans: assert property (p_no_ans) else $error("answer without read");
	// Read data only moves together with an answer.
	property p_rd_hold; !REG_RVALID |-> $stable(REG_RDATA); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	// A rising enabled condition pulls the interrupt within two cycles.
	property p_rot_irq; ROTATE_IRQ_ENABLE && $rose(FRAME_ROTATE_COND) ##1
		(ROTATE_IRQ_ENABLE && !REG_WR) |-> ##[0:2] !IRQ_N; endproperty
	a_rot_irq: assert property (p_rot_irq) else $error("rotate irq missing");
	property p_win_irq; WINDOW_IRQ_ENABLE && $rose(PHASE_WINDOW_COND) ##1
		(WINDOW_IRQ_ENABLE && !REG_WR) |-> ##[0:2] !IRQ_N; endproperty
	a_win_irq: assert property (p_win_irq) else $error("window irq missing");
	property p_trip_irq; TRIP_IRQ_ENABLE && $rose(ALIGN_TRIP_COND) ##1
		(TRIP_IRQ_ENABLE && !REG_WR) |-> ##[0:2] !IRQ_N; endproperty
	a_trip_irq: assert property (p_trip_irq) else $error("trip irq missing");
	property p_lock_irq; LOCK_IRQ_ENABLE && $rose(ALIGN_LOCKED_COND) ##1
		(LOCK_IRQ_ENABLE && !REG_WR) |-> ##[0:2] !IRQ_N; endproperty
	a_lock_irq: assert property (p_lock_irq) else $error("lock irq missing");
	// Without a write or an enable change a latched flag keeps the line low.
	// The line trails the latches by one register, so the write that matters
	// is the one taken at the previous edge, not the one standing now.
	property p_irq_keep; !IRQ_N && !$past(REG_WR) && en == $past(en) |=> !IRQ_N; endproperty
	a_irq_keep: assert property (p_irq_keep) else $error("irq released early");
	// Live bits never drive the interrupt.
	property p_irq_idle; en == 4'h0 && $past(en) == 4'h0 |=> IRQ_N; endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("irq while disabled");
	// Reserved bits read as zero.
	property p_dc_resv; REG_RD && REG_ADDR == lsi_pkg::DC_OVF_ADDR
		|=> REG_RDATA[7:1] == 7'h00; endproperty
	a_dc_resv: assert property (p_dc_resv) else $error("reserved dc bits set");
	property p_chk_resv; REG_RD && REG_ADDR == lsi_pkg::LINK_CHECK_ADDR
		|=> REG_RDATA[7:6] == 2'h0; endproperty
	a_chk_resv: assert property (p_chk_resv) else $error("reserved check bits set");
endmodule
bind lsi_top lsi_monitor u_lsi_monitor (.CLK, .RST, .REG_ADDR, .REG_WR, .REG_RD, .REG_RDATA,
	.REG_RVALID, .ALIGN_LOCKED_COND, .FRAME_ROTATE_COND, .PHASE_WINDOW_COND, .ALIGN_TRIP_COND,
	.LOCK_IRQ_ENABLE, .ROTATE_IRQ_ENABLE, .WINDOW_IRQ_ENABLE, .TRIP_IRQ_ENABLE, .IRQ_N);

// ==== testbench/lsi_top_test.sv ====
`timescale 1ns/10ps
// Register-level tests of the alignment flags and overflow status.
module lsi_top_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] addr = 12'h000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [3:0] cond = 4'h0; // Lock, rotate, window, trip, as in the status bits.
	logic [3:0] en = 4'h0;
	logic [7:0] ovf = 8'h00; // Same order as the datapath overflow bits.
	logic dc = 1'b0;
	logic [5:0] chk = 6'h00;
	logic [7:0] rdata;
	logic rvalid;
	logic irq_n;
	int fail_count = 0;
	int n_compared = 0;
	lsi_top u_lsi_top (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
		.REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .ALIGN_LOCKED_COND(cond[3]),
		.FRAME_ROTATE_COND(cond[2]), .PHASE_WINDOW_COND(cond[1]), .ALIGN_TRIP_COND(cond[0]),
		.LOCK_IRQ_ENABLE(en[3]), .ROTATE_IRQ_ENABLE(en[2]), .WINDOW_IRQ_ENABLE(en[1]),
		.TRIP_IRQ_ENABLE(en[0]), .PROG_FIR_OVF(ovf[7]), .INTERP_STAGE1_OVF(ovf[6]),
		.INTERP_STAGE2_OVF(ovf[5]), .INTERP_STAGE3_OVF(ovf[4]), .EIGHTH_RATE_MIX_OVF(ovf[3]),
		.NCO_MIX_OVF(ovf[2]), .PHASE_TRIM_OVF(ovf[1]), .GAIN_TRIM_OVF(ovf[0]),
		.OFFSET_TRIM_OVF(dc), .LINK_CHECK_ERR(chk), .IRQ_N(irq_n));
	// The clock runs at 25 MHz.
	initial begin
		forever #20 clk = ~clk;
	end
	// Counts one comparison and reports a mismatch at once.
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Moves to just after a later rising edge, where inputs may change safely.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One read strobe; the answer is checked at the edge after it.
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
		tick(1);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		cmp({7'h00, rvalid}, 8'h01);
		cmp(rdata, exp);
	endtask
	// One write strobe; writes carry no answer.
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		tick(1);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
	endtask
	// Prints the verdict and ends the run.
	task automatic give_verdict();
		if (fail_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// A hang is cut short well beyond the roughly 170 cycles the tests need.
	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end
	// Main sequence.
	initial begin
		tick(6);
		rst = 1'b0;
		rd_chk(lsi_pkg::ALIGN_STATUS_ADDR, 8'h00);
		rd_chk(lsi_pkg::DP_OVF_ADDR, 8'h00);
		rd_chk(lsi_pkg::DC_OVF_ADDR, 8'h00);
		rd_chk(lsi_pkg::LINK_CHECK_ADDR, 8'h00);
		rd_chk(12'h031, 8'h00);
		// Live mode: each bit follows its condition and leaves the line high.
		for (int i = 0; i < 4; i++) begin
			cond = 4'h1 << i;
			tick(2);
			rd_chk(lsi_pkg::ALIGN_STATUS_ADDR, 8'h01 << i);
			cmp({7'h00, irq_n}, 8'h01);
			cond = 4'h0;
			tick(2);
			rd_chk(lsi_pkg::ALIGN_STATUS_ADDR, 8'h00);
		end
		// Latched mode: a one-cycle pulse sticks until its own bit is written.
		en = 4'hF;
		for (int i = 0; i < 4; i++) begin
			tick(1);
			cond = 4'h1 << i;
			tick(1);
			cond = 4'h0;
			tick(3);
			cmp({7'h00, irq_n}, 8'h00);
			rd_chk(lsi_pkg::ALIGN_STATUS_ADDR, 8'h01 << i);
			wr_reg(lsi_pkg::ALIGN_STATUS_ADDR, 8'h0F ^ (8'h01 << i));
			rd_chk(lsi_pkg::ALIGN_STATUS_ADDR, 8'h01 << i);
			wr_reg(lsi_pkg::ALIGN_STATUS_ADDR, 8'h01 << i);
			tick(3);
			cmp({7'h00, irq_n}, 8'h01);
			rd_chk(lsi_pkg::ALIGN_STATUS_ADDR, 8'h00);
		end
		// Two latched flags: the line stays low until the second is cleared.
		cond = 4'h5;
		tick(1);
		cond = 4'h0;
		wr_reg(lsi_pkg::ALIGN_STATUS_ADDR, 8'h01);
		tick(3);
		cmp({7'h00, irq_n}, 8'h00);
		wr_reg(lsi_pkg::ALIGN_STATUS_ADDR, 8'h04);
		tick(3);
		cmp({7'h00, irq_n}, 8'h01);
		// Overflow bits walk one at a time; writes to them are ignored.
		for (int i = 0; i < 8; i++) begin
			ovf = 8'h01 << i;
			wr_reg(lsi_pkg::DP_OVF_ADDR, 8'hFF);
			rd_chk(lsi_pkg::DP_OVF_ADDR, 8'h01 << i);
		end
		ovf = 8'h00;
		dc = 1'b1;
		chk = 6'h3F;
		wr_reg(lsi_pkg::DC_OVF_ADDR, 8'hFE);
		rd_chk(lsi_pkg::DC_OVF_ADDR, 8'h01);
		rd_chk(lsi_pkg::LINK_CHECK_ADDR, 8'h3F);
		give_verdict();
	end
endmodule
